// ==== tb.sv ====
// self-checking testbench for the wake-up detector
`timescale 1ns/1ps
module tb
	import wol_pkg::*;
;
	localparam logic [31:0] LH   = 32'h00100000;
	localparam logic [31:0] MSK  = 32'hc0000003;
	localparam logic [47:0] NODE = 48'h112233445566;
	logic          clk_i, rst_i, cyc, stb, we, gpio, ack, wake_event_out, oe, cke, hie;
	logic [11:0]   adr;
	logic [3:0]    sel;
	logic [31:0]   wdat, dat_o, rdat, n;
	logic [1:0]    pd, link;
	wol_rx_t [1:0] rx;
	logic [7:0]    f[$];
	int            err_count, checks, cyc_n;

	wol_detector #(.PULSE_CYCLES(8'h2)) dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
		.wb_dat_o(dat_o), .wb_ack_o(ack), .rx_i(rx), .link_up_i(link), .gpio_wake_i(gpio),
		.pme_o(wake_event_out), .pme_oe_o(oe), .core_clk_en_o(cke), .host_if_en_o(hie),
		.phy_pwr_down_o(pd));
	wol_rx_src src (.clk_i(clk_i), .rx_o(rx));

	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end

	task automatic step(input int k);
		repeat (k) @(posedge clk_i);
	endtask: step

	task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d,
		input logic [3:0] s);
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		sel <= s;
		do @(posedge clk_i); while (ack !== 1'b1);
		rdat = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask: acc

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		acc(1'b1, a, d, 4'hf);
	endtask: wr

	task automatic rd(input logic [11:0] a);
		acc(1'b0, a, 32'h0, 4'hf);
	endtask: rd

	task automatic cmp(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e) begin
			err_count++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask: cmp

	task automatic sr(input logic [31:0] m, input logic [31:0] e);
		rd(WOL_STAT_OFS);
		cmp(rdat & m, e);
	endtask: sr

	task automatic pw(input logic [31:0] e);
		cmp({28'h0, cke, hie, pd}, e);
	endtask: pw

	task automatic d1(input logic [31:0] c);
		wr(WOL_CFG_OFS, c | 32'h00080000);
		wr(WOL_CFG_OFS, c | 32'h00040000);
	endtask: d1

	task automatic pat(input int len);
		f = {};
		for (int i = 0; i < len; i++) begin
			f.push_back(8'(i * 7 + 3));
		end
	endtask: pat

	function automatic logic [31:0] pcrc(input int a, input int b, input int c, input int nw);
		logic [31:0] r;
		int          o[3];
		r = WOL_CRC_INIT;
		o = '{a, b, c};
		for (int w = 0; w < nw; w++) begin
			for (int j = 0; j < 32; j++) begin
				if (MSK[j]) begin
					r = r ^ 32'(f[o[w] + j]);
					for (int k = 0; k < 8; k++) begin
						r = r[0] ? ((r >> 1) ^ WOL_CRC_POLY) : (r >> 1);
					end
				end
			end
		end
		return ~r;
	endfunction: pcrc

	task automatic seq(input logic [47:0] da, input int reps, input logic ok, input logic ex);
		f = {};
		for (int i = 0; i < 18; i++) begin
			f.push_back(i < 6 ? da[47 - 8 * i -: 8] : (i < 12 ? 8'h5a : 8'hff));
		end
		repeat (reps) begin
			for (int i = 0; i < 6; i++) begin
				f.push_back(NODE[47 - 8 * i -: 8]);
			end
		end
		f.push_back(8'h00);
		src.send(0, f, ok);
		sr(ex ? 32'h28 : 32'h8, ex ? 32'h28 : 32'h0);
		wr(WOL_CFG_OFS, LH | 32'h00080002);
	endtask: seq

	task automatic summarize();
		$display("comparisons %0d, mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask: summarize

	// ceiling well above the little over a thousand cycles the sequence needs
	always @(posedge clk_i) begin
		cyc_n++;
		if (cyc_n == 20000) begin
			err_count++;
			summarize();
		end
	end

	initial begin
		rst_i = 1'b1;
		{cyc, stb, we, gpio, adr, sel, wdat, link} = '0;
		{err_count, checks, cyc_n} = '0;
		step(8);
		rst_i <= 1'b0;
		rd(WOL_CFG_OFS);
		cmp(rdat, WOL_CFG_RST);
		rd(12'h000);
		cmp(rdat, 32'h0);
		sr('1, 32'h0);
		pw(32'hc);
		acc(1'b1, WOL_ALO_OFS[0], 32'hffffffff, 4'h3);
		rd(WOL_ALO_OFS[0]);
		cmp(rdat, 32'h0000ffff);
		wr(WOL_CFG_OFS, LH | 32'h20);
		link[0] <= 1'b1;
		step(8);
		cmp({31'h0, wake_event_out}, 32'h0);
		link[1] <= 1'b1;
		step(8);
		cmp({31'h0, wake_event_out}, 32'h1);
		sr(32'h3f8, 32'h88);
		wr(WOL_CFG_OFS, LH | 32'h00080021);
		step(2);
		cmp({31'h0, wake_event_out}, 32'h0);
		link[0] <= 1'b0;
		step(8);
		sr(32'h18, 32'h18);
		wr(WOL_CFG_OFS, LH | 32'h00080020);
		wr(WOL_CFG_OFS, LH | 32'h00020020);
		step(1);
		pw(32'h3);
		sr(32'h3, 32'h2);
		link[1] <= 1'b0;
		step(8);
		pw(32'h3);
		wr(WOL_EXIT_OFS, 32'h0);
		step(1);
		pw(32'hc);
		sr(32'h3, 32'h0);
		wr(WOL_ALO_OFS[0], 32'h33445566);
		wr(WOL_AHI_OFS[0], 32'h1122);
		wr(WOL_CFG_OFS, LH | 32'h00080002);
		seq({6{8'hff}}, 16, 1'b0, 1'b0);
		seq({6{8'hff}}, 15, 1'b1, 1'b0);
		seq(48'h020000000001, 16, 1'b1, 1'b0);
		seq({6{8'hff}}, 16, 1'b1, 1'b1);
		seq(NODE, 16, 1'b1, 1'b1);
		pat(56);
		wr(WOL_MASK_OFS[0], MSK);
		wr(WOL_OFFS_OFS, 32'h531);
		wr(WOL_CRC_OFS[0], pcrc(12, 0, 0, 1));
		d1(LH | 32'h4);
		step(1);
		pw(32'h8);
		src.send(0, f, 1'b0);
		sr(32'hb, 32'h1);
		src.send(0, f, 1'b1);
		sr(32'h4b, 32'h48);
		wr(WOL_OFFS_OFS, 32'h8531);
		d1(LH | 32'h4);
		src.send(0, f, 1'b1);
		sr(32'h4b, 32'h1);
		pat(112);
		wr(WOL_OFFS_OFS, 32'h021);
		wr(WOL_CRC_OFS[0], pcrc(4, 44, 76, 3));
		d1(LH | 32'h1c);
		src.send(0, f, 1'b1);
		sr(32'h4b, 32'h48);
		for (int s = 0; s < 5; s++) begin
			wr(WOL_CFG_OFS, (32'(s) << 20) | 32'h00080000);
			step(2);
			gpio <= 1'b1;
			step(1);
			gpio <= 1'b0;
			n = 32'h0;
			repeat (12) begin
				@(posedge clk_i);
				n = n + ((s == 0) ? oe : (wake_event_out === (s == 1 || s == 3)));
			end
			cmp(n, (s < 3) ? 32'hc : 32'h2);
		end
		summarize();
	end
endmodule: tb

// ==== wol_detector.sv ====
// wake-on-lan detector and sleep control for a two-port switch
// Contract
// - link, sequence and pattern wake each enabled per port in config; gpio wake has no enable
// - config bits 22:20 choose wake output style among five kinds
// - sleep stops internal clock, powers down both phys, holds until exit or a d1 command
// - any write to 0x1f4 leaves sleep or wake-up state to normal
// - link-up change on enabled port (bit 0 or 5) raises a wake event, except in sleep
// - sequence detection enabled by bit 1 for port 0, bit 6 port 1
// - find six 0xff bytes then sixteen unbroken copies of port address
// - sequence frame needs good crc and own or multicast destination
// - frame without the sequence is dropped with no further action
// - mask bit j includes byte start plus j into pattern crc
// - three 4-bit offsets per port, each unit four bytes
// - computed crc compared with port expected crc after masked bytes
// - chain 00: filters independent, any one matching wakes
// - chain 11: starts chained by 32 plus offset, one combined crc
// - bad frame crc never qualifies as wake-up frame
// - destination compare enable bit 15 (port 0) or bit 31 (port 1) also demands address equality
// - per-port 2-bit chain field selects simultaneous or sequential filters
// - in wake-up power state every frame checked against enabled filters
// - wake-up frame signals the output; host later clears and re-arms
// - wake-up state keeps clock and phys, host interface off
//
// Register access over Wishbone is this design's own decision.
`timescale 1ns/1ps

module wol_detector
	import wol_pkg::*;
#(
	parameter logic [7:0] PULSE_CYCLES = WOL_PULSE_CYC
) (
	input  wire logic              clk_i,
	input  wire logic              rst_i,
	input  wire logic              wb_cyc_i,
	input  wire logic              wb_stb_i,
	input  wire logic              wb_we_i,
	input  wire logic [11:0]       wb_adr_i,
	input  wire logic [3:0]        wb_sel_i,
	input  wire logic [31:0]       wb_dat_i,
	output logic      [31:0]       wb_dat_o,
	output logic                   wb_ack_o,
	input  wire wol_rx_t [1:0]     rx_i,
	input  wire logic    [1:0]     link_up_i,
	input  wire logic              gpio_wake_i,
	output logic                   pme_o,
	output logic                   pme_oe_o,
	output logic                   core_clk_en_o,
	output logic                   host_if_en_o,
	output logic      [1:0]        phy_pwr_down_o
);

	wol_state_t s_r;
	wol_state_t s_nxt;

	// per-port bit of the wake configuration
	function automatic logic port_en(input logic [31:0] cfg, input int p, input int ofs);
		return cfg[p*WOL_CFG_STRIDE+ofs];
	endfunction: port_en

	always_comb begin
		wol_port_t        pn;
		logic [7:0]       b;
		logic [47:0]      ea;
		logic [10:0]      cur;
		logic [2:0][10:0] st;
		logic [2:0][3:0]  o;
		logic [4:0]       j;
		logic [1:0]       tgt;
		logic             chain;
		logic             da_eq;
		logic             match;
		logic [5:0]       hits;
		logic             evt;
		logic             go_sleep;
		logic             go_d1;
		logic             go_exit;
		logic             clr_wake;
		logic             active;
		logic             armed;
		logic             gpio_prev;
		pn        = '0;
		b         = '0;
		ea        = '0;
		cur       = '0;
		st        = '0;
		o         = '0;
		j         = '0;
		tgt       = '0;
		chain     = 1'b0;
		da_eq     = 1'b0;
		match     = 1'b0;
		hits      = '0;
		evt       = 1'b0;
		go_sleep  = 1'b0;
		go_d1     = 1'b0;
		go_exit   = 1'b0;
		clr_wake  = 1'b0;
		active    = 1'b0;
		gpio_prev = 1'b0;
		s_nxt     = s_r;
		armed     = s_r.pwr != WOL_SLEEP;

		// bus slave, one wait state per access
		s_nxt.ack = 1'b0;
		if (wb_cyc_i && wb_stb_i && !s_r.ack) begin
			s_nxt.ack  = 1'b1;
			s_nxt.rdat = '0;
			if (wol_hit(wb_adr_i, WOL_CFG_OFS)) begin
				s_nxt.rdat = s_r.cfg;
				s_nxt.rdat[WOL_CFG_WCLR_BIT] = s_r.wake;
				s_nxt.rdat[WOL_CFG_SLEEP_BIT] = s_r.pwr == WOL_SLEEP;
				s_nxt.rdat[WOL_CFG_D1_BIT] = s_r.pwr == WOL_WAKEUP;
				if (wb_we_i) begin
					// command bits 17..19 act as strobes and are never stored
					s_nxt.cfg = wol_wmerge(s_r.cfg, wb_dat_i, wb_sel_i) & ~WOL_CFG_ACT_MASK;
					clr_wake = wb_sel_i[2] && wb_dat_i[WOL_CFG_WCLR_BIT];
					go_sleep = wb_sel_i[2] && wb_dat_i[WOL_CFG_SLEEP_BIT];
					go_d1    = wb_sel_i[2] && wb_dat_i[WOL_CFG_D1_BIT];
				end
			end else if (wol_hit(wb_adr_i, WOL_OFFS_OFS)) begin
				s_nxt.rdat = s_r.offs;
				if (wb_we_i) begin
					s_nxt.offs = wol_wmerge(s_r.offs, wb_dat_i, wb_sel_i);
				end
			end else if (wol_hit(wb_adr_i, WOL_STAT_OFS)) begin
				s_nxt.rdat = {22'h0, s_r.cause, s_r.wake, 1'b0, s_r.pwr};
			end else if (wol_hit(wb_adr_i, WOL_EXIT_OFS)) begin
				// write-only, data value is ignored
				go_exit = wb_we_i;
			end else if (wol_hit(wb_adr_i, WOL_CRC_OFS[0])) begin
				s_nxt.rdat = s_r.crc_exp[0];
				if (wb_we_i) begin
					s_nxt.crc_exp[0] = wol_wmerge(s_r.crc_exp[0], wb_dat_i, wb_sel_i);
				end
			end else if (wol_hit(wb_adr_i, WOL_CRC_OFS[1])) begin
				s_nxt.rdat = s_r.crc_exp[1];
				if (wb_we_i) begin
					s_nxt.crc_exp[1] = wol_wmerge(s_r.crc_exp[1], wb_dat_i, wb_sel_i);
				end
			end else if (wol_hit(wb_adr_i, WOL_MASK_OFS[0])) begin
				s_nxt.rdat = s_r.mask[0];
				if (wb_we_i) begin
					s_nxt.mask[0] = wol_wmerge(s_r.mask[0], wb_dat_i, wb_sel_i);
				end
			end else if (wol_hit(wb_adr_i, WOL_MASK_OFS[1])) begin
				s_nxt.rdat = s_r.mask[1];
				if (wb_we_i) begin
					s_nxt.mask[1] = wol_wmerge(s_r.mask[1], wb_dat_i, wb_sel_i);
				end
			end else if (wol_hit(wb_adr_i, WOL_ALO_OFS[0])) begin
				s_nxt.rdat = s_r.addr_lo[0];
				if (wb_we_i) begin
					s_nxt.addr_lo[0] = wol_wmerge(s_r.addr_lo[0], wb_dat_i, wb_sel_i);
				end
			end else if (wol_hit(wb_adr_i, WOL_ALO_OFS[1])) begin
				s_nxt.rdat = s_r.addr_lo[1];
				if (wb_we_i) begin
					s_nxt.addr_lo[1] = wol_wmerge(s_r.addr_lo[1], wb_dat_i, wb_sel_i);
				end
			end else if (wol_hit(wb_adr_i, WOL_AHI_OFS[0])) begin
				s_nxt.rdat = {16'h0, s_r.addr_hi[0]};
				if (wb_we_i) begin
					s_nxt.addr_hi[0] = 16'(wol_wmerge({16'h0, s_r.addr_hi[0]}, wb_dat_i,
						wb_sel_i));
				end
			end else if (wol_hit(wb_adr_i, WOL_AHI_OFS[1])) begin
				s_nxt.rdat = {16'h0, s_r.addr_hi[1]};
				if (wb_we_i) begin
					s_nxt.addr_hi[1] = 16'(wol_wmerge({16'h0, s_r.addr_hi[1]}, wb_dat_i,
						wb_sel_i));
				end
			end else begin
				// unmapped: acked, reads zero, writes dropped
				s_nxt.rdat = '0;
			end
		end

		// per-port link and frame scanning
		for (int p = 0; p < 2; p++) begin
			pn = s_r.port[p];
			ea = {s_r.addr_hi[p], s_r.addr_lo[p]};
			chain = s_r.cfg[p*WOL_CFG_STRIDE+WOL_CFG_CHAIN_LO +: 2] == WOL_CHAIN_ALL;

			// link change detection after a two-stage synchroniser
			pn.link_s1   = link_up_i[p];
			pn.link_s2   = s_r.port[p].link_s1;
			pn.link_prev = s_r.port[p].link_s2;
			pn.primed    = 1'b1;
			// primed masks the first cycle out of reset
			if (s_r.port[p].primed && s_r.port[p].link_s2 != s_r.port[p].link_prev &&
				port_en(s_r.cfg, p, WOL_CFG_LINK_BIT) && armed) begin
				hits[p*3] = 1'b1;
			end

			for (int f = 0; f < 3; f++) begin
				o[f] = s_r.offs[p*WOL_OFFS_STRIDE+f*WOL_OFFS_FIELD +: WOL_OFFS_FIELD];
			end
			st[0] = {5'h0, o[0], 2'b00};
			for (int f = 1; f < 3; f++) begin
				if (chain) begin
					st[f] = st[f-1] + 11'(WOL_WIN_LEN) + {5'h0, o[f], 2'b00};
				end else begin
					st[f] = {5'h0, o[f], 2'b00};
				end
			end

			if (rx_i[p].valid) begin
				b = rx_i[p].data;
				if (rx_i[p].sof) begin
					pn.pos    = '0;
					pn.ff_cnt = '0;
					pn.hunt   = 1'b0;
					pn.idx    = '0;
					pn.reps   = '0;
					pn.found  = 1'b0;
					pn.crc    = {3{WOL_CRC_INIT}};
				end
				cur = pn.pos;
				if (cur < 11'(WOL_ADDR_LEN)) begin
					pn.da = {pn.da[39:0], b};
				end

				// sync stream then sixteen address copies, anywhere in the frame
				if (!pn.found) begin
					if (pn.hunt) begin
						if (b == wol_addr_byte(ea, pn.idx)) begin
							if (pn.idx == 3'(WOL_ADDR_LEN-1)) begin
								pn.idx = '0;
								if (pn.reps == 5'(WOL_REPEATS-1)) begin
									pn.found = 1'b1;
								end
								pn.reps = pn.reps + 5'h1;
							end else begin
								pn.idx = pn.idx + 3'h1;
							end
						end else if (b == WOL_SYNC_BYTE && pn.idx == '0 && pn.reps == '0) begin
							pn.hunt = 1'b1;
						end else begin
							// a break restarts the search; the byte may open a new sync run
							pn.hunt   = 1'b0;
							pn.idx    = '0;
							pn.reps   = '0;
							pn.ff_cnt = (b == WOL_SYNC_BYTE) ? 3'h1 : 3'h0;
						end
					end else if (b == WOL_SYNC_BYTE) begin
						if (pn.ff_cnt == 3'(WOL_SYNC_LEN-1)) begin
							pn.hunt = 1'b1;
						end else begin
							pn.ff_cnt = pn.ff_cnt + 3'h1;
						end
					end else begin
						pn.ff_cnt = '0;
					end
				end

				// masked crc windows
				// unchained windows may overlap; each filter keeps its own crc
				for (int f = 0; f < 3; f++) begin
					if (cur >= st[f] && cur < st[f] + 11'(WOL_WIN_LEN)) begin
						j = 5'(cur - st[f]);
						tgt = chain ? 2'h0 : 2'(f);
						if (s_r.mask[p][j]) begin
							pn.crc[tgt] = wol_crc_byte(pn.crc[tgt], b);
						end
					end
				end
				if (pn.pos != '1) begin
					pn.pos = pn.pos + 11'h1;
				end

				if (rx_i[p].eof) begin
					// runt frames shorter than an address never count as own address
					da_eq = pn.da == ea && pn.pos >= 11'(WOL_ADDR_LEN);
					// bit 40 is the group bit of the first destination byte
					if (port_en(s_r.cfg, p, WOL_CFG_SEQ_BIT) && armed &&
						rx_i[p].crc_ok && (da_eq || pn.da[40]) && pn.found) begin
						hits[p*3+1] = 1'b1;
					end
					match = 1'b0;
					if (chain) begin
						match = ~pn.crc[0] == s_r.crc_exp[p];
					end else begin
						for (int f = 0; f < 3; f++) begin
							match = match | (~pn.crc[f] == s_r.crc_exp[p]);
						end
					end
					if (port_en(s_r.cfg, p, WOL_CFG_PAT_BIT) && s_r.pwr == WOL_WAKEUP &&
						rx_i[p].crc_ok &&
						(!s_r.offs[p*WOL_OFFS_STRIDE+WOL_OFFS_DACMP] || da_eq) && match) begin
						hits[p*3+2] = 1'b1;
					end
					// frames that miss leave no trace beyond the per-frame scan state
				end
			end
			s_nxt.port[p] = pn;
		end

		// gpio wake arrives already qualified by the gpio block
		gpio_prev = gpio_wake_i && armed;
		evt = (|hits) || gpio_prev;

		// set wins over a simultaneous clear
		s_nxt.wake  = (s_r.wake && !clr_wake) || evt;
		s_nxt.cause = clr_wake ? hits : (s_r.cause | hits);

		// power state
		if (evt || go_exit) begin
			s_nxt.pwr = WOL_NORMAL;
		end else if (go_sleep) begin
			s_nxt.pwr = WOL_SLEEP;
		end else if (go_d1) begin
			s_nxt.pwr = WOL_WAKEUP;
		end
		s_nxt.clk_en  = s_nxt.pwr != WOL_SLEEP;
		s_nxt.host_en = s_nxt.pwr == WOL_NORMAL;
		s_nxt.phy_pd  = {2{s_nxt.pwr == WOL_SLEEP}};

		// wake output styles
		// a new event restarts the pulse, so close events merge into one
		if (evt) begin
			s_nxt.pulse = PULSE_CYCLES;
		end else if (s_r.pulse != '0) begin
			s_nxt.pulse = s_r.pulse - 8'h1;
		end
		case (s_r.cfg[WOL_CFG_STYLE_LO +: 3])
			WOL_PME_PLS_HIGH, WOL_PME_PLS_LOW: active = s_nxt.pulse != '0;
			default:                           active = s_nxt.wake;
		endcase
		case (s_r.cfg[WOL_CFG_STYLE_LO +: 3])
			WOL_PME_ACT_LOW: begin
				// open drain: pulls low only while active
				s_nxt.wake_event_out    = 1'b0;
				s_nxt.pme_oe = active;
			end
			WOL_PME_LVL_LOW, WOL_PME_PLS_LOW: begin
				s_nxt.wake_event_out    = !active;
				s_nxt.pme_oe = 1'b1;
			end
			default: begin
				s_nxt.wake_event_out    = active;
				s_nxt.pme_oe = 1'b1;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_r         <= '0;
			s_r.cfg     <= WOL_CFG_RST;
			s_r.pwr     <= WOL_NORMAL;
			s_r.clk_en  <= 1'b1;
			s_r.host_en <= 1'b1;
			// link synchronisers keep sampling, so no false change follows reset;
			// reset must stand two cycles for them to settle, as primed masks the first cycle after it
			for (int p = 0; p < 2; p++) begin
				s_r.port[p].link_s1   <= s_nxt.port[p].link_s1;
				s_r.port[p].link_s2   <= s_nxt.port[p].link_s2;
				s_r.port[p].link_prev <= s_nxt.port[p].link_prev;
			end
		end else begin
			s_r <= s_nxt;
		end
	end

	assign wb_dat_o       = s_r.rdat;
	assign wb_ack_o       = s_r.ack;
	assign pme_o          = s_r.wake_event_out;
	assign pme_oe_o       = s_r.pme_oe;
	assign core_clk_en_o  = s_r.clk_en;
	assign host_if_en_o   = s_r.host_en;
	assign phy_pwr_down_o = s_r.phy_pd;

endmodule: wol_detector

// ==== wol_detector_chk.sv ====
// port-level checker for the wake-up detector bus, power and exit behaviour
`timescale 1ns/1ps
module wol_detector_chk
	import wol_pkg::*;
(
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [11:0] wb_adr_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	input wire logic        gpio_wake_i,
	input wire logic        pme_o,
	input wire logic        core_clk_en_o,
	input wire logic        host_if_en_o,
	input wire logic [1:0]  phy_pwr_down_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	logic req;
	logic quiet;
	assign req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	// gpio and bus writes are the only causes allowed to end sleep
	assign quiet = ~(wb_cyc_i & wb_stb_i & wb_we_i) & ~gpio_wake_i;

	chk_ack_next: assert property (req |=> wb_ack_o)
		else $error("ack missing after request");
	chk_ack_once: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	chk_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
		else $error("ack without request");
	chk_exit_normal: assert property (
		req && wb_we_i && wb_adr_i[11:2] == WOL_EXIT_OFS[11:2] |=> host_if_en_o && core_clk_en_o)
		else $error("exit write did not restore normal state");
	chk_sleep_power: assert property (
		!core_clk_en_o |-> phy_pwr_down_o == 2'h3 && !host_if_en_o)
		else $error("sleep without phys down");
	chk_sleep_hold: assert property (!core_clk_en_o && quiet |=> !core_clk_en_o)
		else $error("sleep left without cause");
	chk_wake_power: assert property (
		core_clk_en_o && !host_if_en_o |-> phy_pwr_down_o == 2'h0)
		else $error("phys down in wake-up state");
	chk_unmapped_zero: assert property (
		req && !wb_we_i && wb_adr_i[11:8] == 4'h0 |=> wb_dat_o == 32'h0)
		else $error("unmapped read not zero");
	chk_dat_hold: assert property (!(wb_cyc_i && wb_stb_i) |=> $stable(wb_dat_o))
		else $error("read data moved while idle");

	cov_sleep: cover property ($fell(core_clk_en_o));
	cov_wakeup: cover property (core_clk_en_o && !host_if_en_o);
	cov_pme: cover property ($rose(pme_o));
	cov_normal: cover property ($rose(host_if_en_o));
endmodule: wol_detector_chk

bind wol_detector wol_detector_chk u_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
	.wb_adr_i, .wb_dat_o, .wb_ack_o, .gpio_wake_i, .pme_o, .core_clk_en_o, .host_if_en_o,
	.phy_pwr_down_o);

// ==== wol_pkg.sv ====
// wake-up detector register map, field layout, constants, carriers and helpers
package wol_pkg;

	// register byte offsets
	localparam logic [11:0] WOL_CFG_OFS     = 12'h100;
	localparam logic [11:0] WOL_OFFS_OFS    = 12'h104;
	localparam logic [11:0] WOL_STAT_OFS    = 12'h128;
	localparam logic [11:0] WOL_EXIT_OFS    = 12'h1f4;
	localparam logic [1:0][11:0] WOL_CRC_OFS   = {12'h110, 12'h108};
	localparam logic [1:0][11:0] WOL_MASK_OFS  = {12'h114, 12'h10c};
	localparam logic [1:0][11:0] WOL_ALO_OFS   = {12'h120, 12'h118};
	localparam logic [1:0][11:0] WOL_AHI_OFS   = {12'h124, 12'h11c};

	// wake_config_register fields, per-port group repeats every stride bits
	localparam int WOL_CFG_STRIDE   = 5;
	localparam int WOL_CFG_LINK_BIT = 0;
	localparam int WOL_CFG_SEQ_BIT  = 1;
	localparam int WOL_CFG_PAT_BIT  = 2;
	localparam int WOL_CFG_CHAIN_LO = 3;
	localparam int WOL_CFG_SLEEP_BIT = 17;
	localparam int WOL_CFG_D1_BIT   = 18;
	localparam int WOL_CFG_WCLR_BIT = 19;
	localparam int WOL_CFG_STYLE_LO = 20;
	localparam logic [31:0] WOL_CFG_ACT_MASK = 32'h000e0000;
	localparam logic [31:0] WOL_CFG_RST      = 32'h00000000;

	// wake_filter_offset_register fields
	localparam int WOL_OFFS_STRIDE  = 16;
	localparam int WOL_OFFS_FIELD   = 4;
	localparam int WOL_OFFS_DACMP   = 15;

	localparam logic [1:0] WOL_CHAIN_ALL = 2'h3;

	// wake_event_out signalling styles
	localparam logic [2:0] WOL_PME_ACT_LOW  = 3'h0;
	localparam logic [2:0] WOL_PME_LVL_HIGH = 3'h1;
	localparam logic [2:0] WOL_PME_LVL_LOW  = 3'h2;
	localparam logic [2:0] WOL_PME_PLS_HIGH = 3'h3;
	localparam logic [2:0] WOL_PME_PLS_LOW  = 3'h4;
	localparam logic [7:0] WOL_PULSE_CYC    = 8'h10;

	// frame scanning constants
	localparam logic [7:0]  WOL_SYNC_BYTE = 8'hff;
	localparam int          WOL_SYNC_LEN  = 6;
	localparam int          WOL_REPEATS   = 16;
	localparam int          WOL_ADDR_LEN  = 6;
	localparam int          WOL_WIN_LEN   = 32;
	localparam logic [31:0] WOL_CRC_INIT  = 32'hffffffff;
	localparam logic [31:0] WOL_CRC_POLY  = 32'hedb88320;

	typedef enum logic [1:0] {WOL_NORMAL, WOL_WAKEUP, WOL_SLEEP} wol_pwr_t;

	typedef struct packed {
		logic       valid;
		logic       sof;
		logic       eof;
		logic       crc_ok;
		logic [7:0] data;
	} wol_rx_t;

	typedef struct packed {
		logic [10:0]      pos;
		logic [47:0]      da;
		logic [2:0]       ff_cnt;
		logic             hunt;
		logic [2:0]       idx;
		logic [4:0]       reps;
		logic             found;
		logic [2:0][31:0] crc;
		logic             primed;
		logic             link_s1;
		logic             link_s2;
		logic             link_prev;
	} wol_port_t;

	typedef struct packed {
		wol_pwr_t         pwr;
		logic [31:0]      cfg;
		logic [31:0]      offs;
		logic [1:0][31:0] crc_exp;
		logic [1:0][31:0] mask;
		logic [1:0][31:0] addr_lo;
		logic [1:0][15:0] addr_hi;
		logic             wake;
		logic [5:0]       cause;
		logic [7:0]       pulse;
		logic             wake_event_out;
		logic             pme_oe;
		logic             ack;
		logic [31:0]      rdat;
		logic             clk_en;
		logic             host_en;
		logic [1:0]       phy_pd;
		wol_port_t [1:0]  port;
	} wol_state_t;

	function automatic logic wol_hit(input logic [11:0] adr, input logic [11:0] ofs);
		return adr[11:2] == ofs[11:2];
	endfunction: wol_hit

	function automatic logic [31:0] wol_wmerge(input logic [31:0] old_v,
		input logic [31:0] wr_v, input logic [3:0] sel);
		logic [31:0] r;
		r = old_v;
		for (int k = 0; k < 4; k++) begin
			if (sel[k]) begin
				r[k*8 +: 8] = wr_v[k*8 +: 8];
			end
		end
		return r;
	endfunction: wol_wmerge

	function automatic logic [31:0] wol_crc_byte(input logic [31:0] c, input logic [7:0] d);
		logic [31:0] r;
		r = c;
		for (int k = 0; k < 8; k++) begin
			r = (r[0] ^ d[k]) ? ((r >> 1) ^ WOL_CRC_POLY) : (r >> 1);
		end
		return r;
	endfunction: wol_crc_byte

	// first transmitted address byte is bits 47:40
	function automatic logic [7:0] wol_addr_byte(input logic [47:0] a, input logic [2:0] i);
		return a[8*(WOL_ADDR_LEN-1-int'(i)) +: 8];
	endfunction: wol_addr_byte

endpackage: wol_pkg

// ==== wol_rx_src.sv ====
// frame source standing in for the two receive phy paths
`timescale 1ns/1ps
module wol_rx_src
	import wol_pkg::*;
(
	input  wire logic     clk_i,
	output wol_rx_t [1:0] rx_o
);
	initial rx_o = '0;
	// idle data is inverted so a stale byte never passes for a live one
	task automatic send(input int p, input logic [7:0] f[$], input logic ok);
		for (int i = 0; i < f.size(); i++) begin
			@(posedge clk_i);
			rx_o[p] <= '{1'b1, i == 0, i == f.size() - 1, ok, f[i]};
		end
		@(posedge clk_i);
		rx_o[p] <= '{1'b0, 1'b0, 1'b0, ~ok, ~f[f.size() - 1]};
	endtask: send
endmodule: wol_rx_src
